// File: pkg/rps_pkg.sv
package rps_pkg;

    // ----------------------------------------------------------------
    // geometry
    // ----------------------------------------------------------------
    localparam int ADDR_W = 13;
    localparam int WORD_W = 8;
    localparam int WORDS = 8192;

    // ----------------------------------------------------------------
    // apb register offsets
    // ----------------------------------------------------------------
    localparam logic [11:0] OFS_PRESET = 12'h000;
    localparam logic [11:0] OFS_PROG = 12'h004;
    localparam logic [11:0] OFS_STATUS = 12'h008;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int PROG_DATA_LSB = 0;
    localparam int PROG_ADDR_LSB = 8;
    localparam int STAT_PIPE_LSB = 0;
    localparam int STAT_DIAG_LSB = 8;
    localparam int STAT_OE_BIT = 16;
    localparam int STAT_MODE_BIT = 17;
    localparam int STAT_INIT_BIT = 18;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_PRESET = 8'h00;
    localparam logic [7:0] RST_PIPE = 8'h00;
    localparam logic [7:0] RST_DIAG = 8'h00;
    localparam logic RST_OE = 1'b0;
    localparam logic [31:0] RST_RDATA = 32'h0000_0000;

    // ----------------------------------------------------------------
    // what the pipeline and diagnostic registers do at a clock event
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        RPS_PIPE_HOLD = 2'b00,
        RPS_PIPE_ARRAY = 2'b01,
        RPS_PIPE_DIAG = 2'b10,
        RPS_PIPE_PRESET = 2'b11
    } rps_pipe_op_t;

    typedef enum logic [1:0] {
        RPS_DIAG_HOLD = 2'b00,
        RPS_DIAG_SHIFT = 2'b01,
        RPS_DIAG_LOAD = 2'b10
    } rps_diag_op_t;

endpackage : rps_pkg

// File: src/rps_array.sv
`timescale 1ns/10ps
`default_nettype none

module rps_array #(
    parameter int ADDR_W = rps_pkg::ADDR_W,
    parameter int WORD_W = rps_pkg::WORD_W
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // programming port
    input wire logic prog_en,
    input wire logic [ADDR_W-1:0] prog_addr,
    input wire logic [WORD_W-1:0] prog_data,
    // read port
    input wire logic [ADDR_W-1:0] rd_addr,
    output logic [WORD_W-1:0] rd_data
);

    localparam int DEPTH = 1 << ADDR_W;

    logic [WORD_W-1:0] mem_q [DEPTH];

    // ----------------------------------------------------------------
    // cell storage, blank cells read as zero
    // ----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++)
        begin : g_cell
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    mem_q[gi] <= '0;
                end
                else if (prog_en && (prog_addr == ADDR_W'(gi)))
                begin
                    mem_q[gi] <= mem_q[gi] | prog_data;
                end
            end
        end
    endgenerate

    assign rd_data = mem_q[rd_addr];

endmodule : rps_array

`default_nettype wire

// File: src/rps_top.sv
// Behaviour
// - select low gives normal pipeline mode
// - pipeline edge captures addressed array word
// - thirteen address inputs, eight data outputs
// - sync enable: gate low at edge enables
// - sync enable: gate high at edge floats
// - async enable: gate low drives, else float
// - initialize falling edge loads preset byte
// - preset byte is extra location, init only
// - initialize low blocks pipeline clock edges
// - split clocks: scan edge shifts serial data
// - split clocks: shifting runs alongside normal pipeline operation
// - split diagnostic: pipeline edge copies scan register
// - split diagnostic: scan edge loads output pins
// - shared clock: select picks pipeline or diagnostic
// - shared pin as init: outputs always enabled
// - shared pin as enable: same as split
// - shared diagnostic, pin high: shift toward msb
// - serial output shows scan register msb
// - shared transfer, serial low: scan to pipeline
// - shared transfer, serial high: pins to scan
// - shared transfer: serial output follows serial input
//
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none

module rps_top #(
    parameter int ADDR_W = rps_pkg::ADDR_W,
    parameter int WORD_W = rps_pkg::WORD_W,
    parameter bit SINGLE_CLK = 1'b0,
    parameter bit SYNC_ENABLE = 1'b1,
    parameter bit SHARED_IS_INIT = 1'b0
) (
    // apb clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // sequencer side
    input wire logic pipe_clk,
    input wire logic [ADDR_W-1:0] word_addr,
    input wire logic output_gate_n,
    input wire logic init_n,
    // scan side
    input wire logic diag_sel,
    input wire logic scan_clk,
    input wire logic scan_in,
    output logic scan_out,
    // data bus pins
    input wire logic [WORD_W-1:0] word_in,
    output logic [WORD_W-1:0] word_out,
    output logic word_oe
);

    // ----------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------
    generate
        if (WORD_W != rps_pkg::WORD_W || ADDR_W < 1 || ADDR_W > 16)
        begin : g_bad_geometry
            $error("rps_top: unsupported word or address width");
        end
        if (SINGLE_CLK == 1'b0 && SHARED_IS_INIT == 1'b1)
        begin : g_bad_config
            $error("rps_top: shared init pin only exists with a single clock");
        end
    endgenerate

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [WORD_W-1:0] pipe_q;
    logic [WORD_W-1:0] diag_q;
    logic [WORD_W-1:0] preset_q;
    logic oe_q;
    logic scan_out_q;
    logic pipe_clk_q;
    logic scan_clk_q;
    logic init_pin_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic [WORD_W-1:0] array_word;
    logic [WORD_W-1:0] pin_word;
    logic pipe_rise;
    logic scan_rise;
    logic init_pin;
    logic init_low;
    logic init_fall;
    logic xfer_mode;
    logic prog_en;
    rps_pkg::rps_pipe_op_t pipe_op;
    rps_pkg::rps_diag_op_t diag_op;

    // ----------------------------------------------------------------
    // array storage
    // ----------------------------------------------------------------
    rps_array #(
        .ADDR_W(ADDR_W),
        .WORD_W(WORD_W)
    ) u_array (
        .pclk(pclk),
        .presetn(presetn),
        .prog_en(prog_en),
        .prog_addr(pwdata[rps_pkg::PROG_ADDR_LSB +: ADDR_W]),
        .prog_data(pwdata[rps_pkg::PROG_DATA_LSB +: WORD_W]),
        .rd_addr(word_addr),
        .rd_data(array_word)
    );

    // ----------------------------------------------------------------
    // pin edge detection
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pipe_clk_q <= 1'b0;
            scan_clk_q <= 1'b0;
            init_pin_q <= 1'b1;
        end
        else
        begin
            pipe_clk_q <= pipe_clk;
            scan_clk_q <= scan_clk;
            init_pin_q <= init_pin;
        end
    end

    assign pipe_rise = pipe_clk & ~pipe_clk_q;
    assign scan_rise = scan_clk & ~scan_clk_q;

    // the initialize function lives on its own pin or on the shared pin
    assign init_pin = SINGLE_CLK ? (SHARED_IS_INIT ? output_gate_n : 1'b1) : init_n;
    // on the shared pin, a low in diagnostic mode is a sub-mode, not init
    assign init_low = ~init_pin & ~(SINGLE_CLK & diag_sel);
    assign init_fall = init_pin_q & ~init_pin & ~(SINGLE_CLK & diag_sel);

    // shared clock parallel-transfer sub-mode
    assign xfer_mode = SINGLE_CLK & diag_sel & ~output_gate_n;

    // value seen on the data pins
    assign pin_word = oe_q ? pipe_q : word_in;

    // ----------------------------------------------------------------
    // pipeline register action
    // ----------------------------------------------------------------
    always_comb
    begin
        pipe_op = rps_pkg::RPS_PIPE_HOLD;
        if (init_fall)
        begin
            pipe_op = rps_pkg::RPS_PIPE_PRESET;
        end
        else if (pipe_rise && !init_low)
        begin
            if (!diag_sel)
            begin
                pipe_op = rps_pkg::RPS_PIPE_ARRAY;
            end
            else if (!SINGLE_CLK)
            begin
                pipe_op = rps_pkg::RPS_PIPE_DIAG;
            end
            else if (xfer_mode && !scan_in)
            begin
                pipe_op = rps_pkg::RPS_PIPE_DIAG;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pipe_q <= rps_pkg::RST_PIPE;
        end
        else
        begin
            unique case (pipe_op)
                rps_pkg::RPS_PIPE_HOLD: pipe_q <= pipe_q;
                rps_pkg::RPS_PIPE_ARRAY: pipe_q <= array_word;
                rps_pkg::RPS_PIPE_DIAG: pipe_q <= diag_q;
                rps_pkg::RPS_PIPE_PRESET: pipe_q <= preset_q;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // diagnostic register action
    // ----------------------------------------------------------------
    always_comb
    begin
        diag_op = rps_pkg::RPS_DIAG_HOLD;
        if (!SINGLE_CLK)
        begin
            // own scan clock, independent of the pipeline clock
            if (scan_rise)
            begin
                diag_op = diag_sel ? rps_pkg::RPS_DIAG_LOAD
                                   : rps_pkg::RPS_DIAG_SHIFT;
            end
        end
        else if (pipe_rise && diag_sel)
        begin
            if (output_gate_n)
            begin
                diag_op = rps_pkg::RPS_DIAG_SHIFT;
            end
            else if (scan_in)
            begin
                diag_op = rps_pkg::RPS_DIAG_LOAD;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            diag_q <= rps_pkg::RST_DIAG;
        end
        else
        begin
            unique case (diag_op)
                rps_pkg::RPS_DIAG_HOLD: diag_q <= diag_q;
                rps_pkg::RPS_DIAG_SHIFT: diag_q <= {diag_q[WORD_W-2:0], scan_in};
                rps_pkg::RPS_DIAG_LOAD: diag_q <= pin_word;
                default: diag_q <= diag_q;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // serial output
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            scan_out_q <= 1'b0;
        end
        else if (xfer_mode)
        begin
            scan_out_q <= scan_in;
        end
        else if (diag_op == rps_pkg::RPS_DIAG_SHIFT)
        begin
            scan_out_q <= diag_q[WORD_W-2];
        end
        else if (diag_op == rps_pkg::RPS_DIAG_LOAD)
        begin
            scan_out_q <= pin_word[WORD_W-1];
        end
        else
        begin
            scan_out_q <= diag_q[WORD_W-1];
        end
    end

    // ----------------------------------------------------------------
    // output enable
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            oe_q <= rps_pkg::RST_OE;
        end
        else if (SINGLE_CLK && SHARED_IS_INIT)
        begin
            oe_q <= 1'b1;
        end
        else if (SINGLE_CLK && diag_sel)
        begin
            // shared pin is a sub-mode select here; enable state holds
            oe_q <= oe_q;
        end
        else if (SYNC_ENABLE)
        begin
            if (pipe_rise && !init_low)
            begin
                oe_q <= ~output_gate_n;
            end
        end
        else
        begin
            oe_q <= ~output_gate_n;
        end
    end

    // ----------------------------------------------------------------
    // apb slave
    // ----------------------------------------------------------------
    assign prog_en = psel & penable & pready_q & pwrite & (paddr == rps_pkg::OFS_PROG);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            preset_q <= rps_pkg::RST_PRESET;
        end
        else if (psel && penable && pready_q && pwrite && paddr == rps_pkg::OFS_PRESET)
        begin
            preset_q <= pwdata[WORD_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= rps_pkg::RST_RDATA;
        end
        else if (psel && !penable)
        begin
            pready_q <= 1'b1;
            pslverr_q <= 1'b0;
            prdata_q <= rps_pkg::RST_RDATA;
            unique case (paddr)
                rps_pkg::OFS_PRESET:
                begin
                    prdata_q[WORD_W-1:0] <= pwrite ? '0 : preset_q;
                end
                rps_pkg::OFS_PROG:
                begin
                    prdata_q <= rps_pkg::RST_RDATA;
                end
                rps_pkg::OFS_STATUS:
                begin
                    pslverr_q <= pwrite;
                    if (!pwrite)
                    begin
                        prdata_q[rps_pkg::STAT_PIPE_LSB +: WORD_W] <= pipe_q;
                        prdata_q[rps_pkg::STAT_DIAG_LSB +: WORD_W] <= diag_q;
                        prdata_q[rps_pkg::STAT_OE_BIT] <= oe_q;
                        prdata_q[rps_pkg::STAT_MODE_BIT] <= diag_sel;
                        prdata_q[rps_pkg::STAT_INIT_BIT] <= init_low;
                    end
                end
                default:
                begin
                    pslverr_q <= 1'b1;
                end
            endcase
        end
        else
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= rps_pkg::RST_RDATA;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign word_out = pipe_q;
    assign word_oe = oe_q;
    assign scan_out = scan_out_q;
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

endmodule : rps_top

`default_nettype wire

// File: verif/rps_top_assertions.sv
`timescale 1ns/10ps
`default_nettype none

module rps_top_assertions #(
    parameter int WORD_W = rps_pkg::WORD_W,
    parameter bit SINGLE_CLK = 1'b0
) (
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // pins
    input wire logic pipe_clk,
    input wire logic output_gate_n,
    input wire logic init_n,
    input wire logic scan_clk,
    input wire logic diag_sel,
    input wire logic scan_in,
    input wire logic scan_out,
    input wire logic [WORD_W-1:0] word_out,
    input wire logic word_oe
);
    logic [7:0] preset_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            preset_q <= rps_pkg::RST_PRESET;
        else if (psel && penable && pready && pwrite && paddr == rps_pkg::OFS_PRESET)
            preset_q <= pwdata[7:0];
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence pipe_ok_s;
        !SINGLE_CLK && $rose(pipe_clk) && init_n && $past(init_n);
    endsequence
    sequence quiet_s;
        !$rose(pipe_clk) && !$fell(init_n);
    endsequence
    sequence setup_s;
        psel && !penable;
    endsequence

    sync_enable_a: assert property (pipe_ok_s |=> word_oe == !$past(output_gate_n))
        else $error("enable not taken at pipeline edge");
    oe_steady_a: assert property (!$rose(pipe_clk) |=> $stable(word_oe))
        else $error("enable moved without pipeline edge");
    init_block_a: assert property (!SINGLE_CLK && $rose(pipe_clk) && !init_n && !$past(init_n)
        |=> $stable(word_out) && $stable(word_oe))
        else $error("pipeline edge acted during initialize");
    out_steady_a: assert property (quiet_s |=> $stable(word_out))
        else $error("pipeline register moved without cause");
    preset_load_a: assert property (!SINGLE_CLK && $fell(init_n) |=> word_out == preset_q)
        else $error("initialize did not load preset byte");
    scan_steady_a: assert property (!SINGLE_CLK && !$rose(scan_clk) |=> $stable(scan_out))
        else $error("serial output moved without scan edge");
    shared_xfer_a: assert property (SINGLE_CLK && diag_sel && !output_gate_n
        |=> scan_out == $past(scan_in))
        else $error("serial output did not follow serial input");
    ready_pulse_a: assert property (setup_s |=> pready ##1 !pready)
        else $error("ready not a single access cycle");
    bad_access_a: assert property (psel && !penable && (paddr > 12'h008 || paddr[1:0] != 2'h0
        || (pwrite && paddr == 12'h008)) |=> pslverr && prdata == 32'h0)
        else $error("refused access not flagged");
endmodule : rps_top_assertions

bind rps_top rps_top_assertions #(.WORD_W(WORD_W), .SINGLE_CLK(SINGLE_CLK)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pipe_clk(pipe_clk), .output_gate_n(output_gate_n), .init_n(init_n),
    .scan_clk(scan_clk), .diag_sel(diag_sel), .scan_in(scan_in), .scan_out(scan_out),
    .word_out(word_out), .word_oe(word_oe)
);

`default_nettype wire

// File: verif/rps_seq_model.sv
`timescale 1ns/10ps
`default_nettype none

module rps_seq_model (
    // clock
    input wire logic pclk,
    // device data pins
    input wire logic [7:0] word_out,
    input wire logic word_oe,
    // sequencer and scan pins
    output logic pipe_clk,
    output logic [rps_pkg::ADDR_W-1:0] word_addr,
    output logic output_gate_n,
    output logic init_n,
    output logic diag_sel,
    output logic scan_clk,
    output logic scan_in,
    output logic [7:0] word_in,
    output logic [7:0] ext_q
);
    // bus level: device wins while driving
    assign word_in = word_oe ? word_out : ext_q;

    initial
    begin
        pipe_clk = 1'b0;
        scan_clk = 1'b0;
        word_addr = '0;
        output_gate_n = 1'b1;
        init_n = 1'b1;
        diag_sel = 1'b0;
        scan_in = 1'b0;
        ext_q = 8'h00;
    end

    // one clock pulse, pins held through the rising sample
    task automatic clock(input logic p, input logic s, input logic [12:0] a,
        input logic g, input logic si, input logic d);
        @(posedge pclk);
        pipe_clk <= p;
        scan_clk <= s;
        word_addr <= a;
        output_gate_n <= g;
        scan_in <= si;
        diag_sel <= d;
        ext_q <= 8'($urandom);
        @(posedge pclk);
        pipe_clk <= 1'b0;
        scan_clk <= 1'b0;
        @(posedge pclk);
    endtask : clock

    // clocks stay low around initialize changes
    task automatic set_init(input logic v);
        @(posedge pclk);
        init_n <= v;
        @(posedge pclk);
        @(posedge pclk);
    endtask : set_init
endmodule : rps_seq_model

`default_nettype wire

// File: verif/rps_top_test.sv
`timescale 1ns/10ps
`default_nettype none

module rps_top_test;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr, output_gate_n, init_n;
    logic pipe_clk, diag_sel, scan_clk, scan_in, scan_out, word_oe, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [12:0] word_addr;
    logic [7:0] word_in, word_out;
    logic [7:0] ext, sc_word_out;
    logic sc_word_oe, sc_scan_out;
    int sc_pipe, sc_diag;
    bit sc_oe;
    int n_fail, n_tests, cyc, pipe_m, diag_m, preset_m, a, v;
    int mem_m[8192];
    int addrs[$];
    bit oe_m, init_m = 1'b1;

    always #5 pclk = ~pclk;

    rps_top u_rps_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pipe_clk(pipe_clk), .word_addr(word_addr),
        .output_gate_n(output_gate_n), .init_n(init_n), .diag_sel(diag_sel),
        .scan_clk(scan_clk), .scan_in(scan_in), .scan_out(scan_out), .word_in(word_in),
        .word_out(word_out), .word_oe(word_oe));
    rps_seq_model u_seq (.pclk(pclk), .word_out(word_out), .word_oe(word_oe),
        .pipe_clk(pipe_clk), .word_addr(word_addr), .output_gate_n(output_gate_n),
        .init_n(init_n), .diag_sel(diag_sel), .scan_clk(scan_clk), .scan_in(scan_in),
        .word_in(word_in), .ext_q(ext));
    // shared clock variant on the same pins
    rps_top #(.SINGLE_CLK(1'b1)) u_rps_top_sc (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(),
        .pready(), .pslverr(), .pipe_clk(pipe_clk), .word_addr(word_addr),
        .output_gate_n(output_gate_n), .init_n(init_n), .diag_sel(diag_sel),
        .scan_clk(scan_clk), .scan_in(scan_in), .scan_out(sc_scan_out), .word_in(ext),
        .word_out(sc_word_out), .word_oe(sc_word_oe));

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic report_and_stop();
        if (n_fail == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop

    task automatic apb(input bit wr, input int ad, input int wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= 12'(ad);
        pwdata <= 32'(wd);
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk("ready", 32'(pready), 32'h1);
    endtask : apb

    // one pin event, model updated beside it
    task automatic step(input bit p, input bit s, input int ad, input bit g, input bit si,
        input bit d);
        int pins;
        int sc_pins;
        u_seq.clock(p, s, 13'(ad), g, si, d);
        pins = oe_m ? pipe_m : int'(ext);
        sc_pins = sc_oe ? sc_pipe : int'(ext);
        if (p)
        begin
            if (!d)
            begin
                sc_pipe = mem_m[ad];
                sc_oe = !g;
            end
            else if (g)
                sc_diag = ((sc_diag << 1) | si) & 255;
            else if (si)
                sc_diag = sc_pins;
            else
                sc_pipe = sc_diag;
        end
        if (p && init_m)
        begin
            pipe_m = d ? diag_m : mem_m[ad];
            oe_m = !g;
        end
        if (s)
            diag_m = d ? pins : ((diag_m << 1) | si) & 255;
        chk("word_out", 32'(word_out), 32'(pipe_m));
        chk("word_oe", 32'(word_oe), 32'(oe_m));
        chk("scan_out", 32'(scan_out), 32'(diag_m >> 7));
        chk("sc_word_out", 32'(sc_word_out), 32'(sc_pipe));
        chk("sc_word_oe", 32'(sc_word_oe), 32'(sc_oe));
        chk("sc_scan_out", 32'(sc_scan_out), 32'((d && !g) ? si : sc_diag >> 7));
    endtask : step

    task automatic status(input bit d);
        apb(1'b0, 8, 0);
        chk("status", rd, {13'h0, !init_m, d, oe_m, 8'(diag_m), 8'(pipe_m)});
    endtask : status

    always @(posedge pclk)
    begin
        cyc++;
        if (cyc > 20000)
        begin
            n_fail++;
            report_and_stop();
        end
    end

    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        void'($urandom(32'h8fca));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        status(1'b0);
        apb(1'b0, 12'h00C, 0);
        chk("unmapped", {err, rd[30:0]}, 32'h8000_0000);
        apb(1'b1, 8, 32'hFF);
        chk("ro_write", 32'(err), 32'h1);
        addrs = '{0, 8191, $urandom_range(8190, 1)};
        foreach (addrs[i])
        begin
            repeat (2)
            begin
                v = $urandom_range(255, 0);
                mem_m[addrs[i]] |= v;
                apb(1'b1, 4, (addrs[i] << 8) | v);
            end
        end
        foreach (addrs[i])
            step(1'b1, 1'b0, addrs[i], 1'b0, 1'b0, 1'b0);
        step(1'b1, 1'b0, addrs[2], 1'b1, 1'b0, 1'b0);
        preset_m = $urandom_range(255, 1);
        apb(1'b1, 0, preset_m);
        apb(1'b0, 0, 0);
        chk("preset", rd, 32'(preset_m));
        u_seq.set_init(1'b0);
        init_m = 1'b0;
        pipe_m = preset_m;
        chk("init_load", 32'(word_out), 32'(pipe_m));
        step(1'b1, 1'b0, addrs[1], 1'b0, 1'b0, 1'b0);
        status(1'b0);
        u_seq.set_init(1'b1);
        init_m = 1'b1;
        repeat (10)
        begin
            a = addrs[$urandom_range(2, 0)];
            step(1'($urandom), 1'b1, a, 1'b0, 1'($urandom), 1'b0);
        end
        step(1'b0, 1'b1, 0, 1'b0, 1'b0, 1'b1);
        step(1'b1, 1'b0, 0, 1'b1, 1'b0, 1'b1);
        step(1'b0, 1'b1, 0, 1'b1, 1'b0, 1'b1);
        step(1'b1, 1'b1, 0, 1'b0, 1'b0, 1'b1);
        step(1'b1, 1'b0, 0, 1'b0, 1'b1, 1'b1);
        step(1'b1, 1'b0, 0, 1'b1, 1'b1, 1'b1);
        step(1'b1, 1'b0, 0, 1'b0, 1'b0, 1'b1);
        status(1'b1);
        report_and_stop();
    end
endmodule : rps_top_test

`default_nettype wire
